/* design/crl_loader.v */
// Register loader: host and EPROM paths of a cascaded convolver
`timescale 1ns/10ps
`include "crl_map.vh"
// Operation
// - Head device takes 7-bit register address high, data on low eight pins.
// - Data pins drive only on a single device; otherwise inputs.
// - Later devices take address and data from the previous expansion output.
// - With load active, registers are written in any order.
// - Master derives timing strobe from host strobe; chain returns it as acknowledge.
// - Acknowledge tells host last device has the data.
// - Reads drive data pins on single device, final result on last.
// - Earlier devices forward read data down chain; valid at acknowledge low.
// - EPROM master counts addresses for 16 devices, drives load and strobe.
// - EPROM strobe ends on returned chain timing; single loops internally.
// - EPROM timing from internal oscillator, independent of pixel clock.
// - EPROM load starts after reset release, shown by load signal low.
// - Per 128-location page load nine control and top 64 coefficients.
// - Master drives lower 7 EPROM address bits on upper pins.
// - Master repeats per device, drives four page bits for select decode.
// - First mode register bits 3:0 give number of devices loaded, less one.
// - Chip select falling on an idle head device in EPROM mode starts a fresh EPROM load; a fall during a load is ignored.
// - Load signal stays active until last register of final device written.
// - Loading stops when page counter equals the device count.
// - Control at 00-08, coefficients 0-63 at 40-7F ascending.
module crl_loader (
  input wire CORE_CLK,
  input wire SYS_RST,
  input wire ROLE_SINGLE,
  input wire ROLE_MASTER_N,
  input wire BOOT_SOURCE_SEL,
  input wire CHIP_SEL_N,
  input wire READ_NOT_WRITE,
  input wire HOST_STROBE_N_IN,
  output reg HOST_STROBE_N_OUT,
  output reg HOST_STROBE_OE,
  input wire CONFIG_LOAD_ACTIVE_N_IN,
  output reg CONFIG_LOAD_ACTIVE_N_OUT,
  output reg CONFIG_LOAD_ACTIVE_OE,
  input wire [6:0] EXPANSION_ADDR_HIGH_IN,
  output reg [6:0] EXPANSION_ADDR_HIGH_OUT,
  output reg EXPANSION_ADDR_HIGH_OE,
  input wire [7:0] EXPANSION_DATA_LOW_IN,
  output reg [7:0] EXPANSION_DATA_LOW_OUT,
  output reg EXPANSION_DATA_LOW_OE,
  input wire READ_FWD_IN,
  output reg READ_FWD_OUT,
  output reg [6:0] EXP_FWD_ADDR,
  output reg [7:0] EXP_FWD_DATA,
  input wire CHAIN_TIMING_IN_N,
  output reg CHAIN_TIMING_OUT_N,
  output reg [7:0] FINAL_RESULT_OUT,
  output reg [3:0] PAGE_ADDR_OUT
);

localparam [31:0] ACC_RAW = (`CRL_EPROM_ACC_NS + `CRL_CLK_PERIOD_NS - 1)
  / `CRL_CLK_PERIOD_NS + `CRL_SYNC_CYC;
// Access wait rounds up, then covers the data synchroniser
localparam [7:0] ACC_CYC = ACC_RAW[7:0];

////////////////////////////////////////////////////////////////////////
// Pin synchronisers
reg [23:0] sync_a;
reg [23:0] sync_b;
always @(posedge CORE_CLK)
begin
  if (SYS_RST)
  begin
    // Idle pin levels, so no false edge or forward flag after reset
    sync_a <= `CRL_SYNC_RST;
    sync_b <= `CRL_SYNC_RST;
  end
  else
  begin
    sync_a <= {ROLE_SINGLE, ROLE_MASTER_N, BOOT_SOURCE_SEL, CHIP_SEL_N,
      READ_NOT_WRITE, HOST_STROBE_N_IN, CONFIG_LOAD_ACTIVE_N_IN,
      CHAIN_TIMING_IN_N, READ_FWD_IN, EXPANSION_ADDR_HIGH_IN,
      EXPANSION_DATA_LOW_IN};
    sync_b <= sync_a;
  end
end

wire single = sync_b[23];
wire head = sync_b[23] | ~sync_b[22];
wire eprom_mode = head & ~sync_b[21];
wire cs_act = ~sync_b[20];
wire rnw = sync_b[19];
wire stb_act = ~sync_b[18];
wire config_load_active_act = ~sync_b[17];
wire chain_act = ~sync_b[16];
wire rd_fwd_in = sync_b[15];
wire [6:0] s_addr = sync_b[14:8];
wire [7:0] s_data = sync_b[7:0];

////////////////////////////////////////////////////////////////////////
// Register file and address map
reg [7:0] regs [0:72];
integer i;

// Unmapped window maps to all ones; callers drop it
function [7:0] idx_of;
  input [6:0] a;
  begin
    if (a <= `CRL_LAST_CTRL)
      idx_of = {1'b0, a};
    else if (a >= `CRL_COEF_BASE)
      idx_of = 8'h09 + {2'b00, a[5:0]};
    else
      idx_of = 8'hff;
  end
endfunction

wire [3:0] dev_count = regs[0][`CRL_COUNT_MSB:`CRL_COUNT_LSB];

////////////////////////////////////////////////////////////////////////
// EPROM sequencer state
reg [3:0] state;
reg [3:0] next_state;
reg [6:0] loc;
reg [6:0] next_loc;
reg [3:0] page;
reg [3:0] next_page;
reg [7:0] acc_cnt;
reg [7:0] next_acc_cnt;
reg ld;
reg next_ld;
reg stb;
reg next_stb;
reg boot_pend;
reg cs_d;
reg ep_wr;

wire cs_fall = cs_act & ~cs_d;
wire loop_on = single | chain_act;
wire loop_off = single | ~chain_act;

always @*
begin
  next_state = state;
  next_loc = loc;
  next_page = page;
  next_acc_cnt = acc_cnt;
  next_ld = ld;
  next_stb = stb;
  ep_wr = 1'b0;
  case (state)
    `CRL_ST_IDLE:
    begin
      if (eprom_mode & (boot_pend | cs_fall))
      begin
        next_loc = 7'h00;
        next_page = 4'h0;
        next_acc_cnt = 8'h00;
        next_ld = 1'b1;
        next_state = `CRL_ST_SETUP;
      end
    end
    `CRL_ST_SETUP:
    begin
      // Core clock doubles as the free oscillator; no pixel clock used
      if (acc_cnt >= ACC_CYC - 8'h01)
      begin
        next_stb = 1'b1;
        next_state = `CRL_ST_STROBE;
      end
      else
        next_acc_cnt = acc_cnt + 8'h01;
    end
    `CRL_ST_STROBE:
    begin
      if (loop_on)
      begin
        // Master keeps only the bottom page for itself
        ep_wr = (page == 4'h0);
        next_stb = 1'b0;
        next_state = `CRL_ST_RELEASE;
      end
    end
    `CRL_ST_RELEASE:
    begin
      if (loop_off)
      begin
        next_acc_cnt = 8'h00;
        next_state = `CRL_ST_SETUP;
        if (loc == `CRL_LAST_LOC)
        begin
          next_loc = 7'h00;
          if (page == dev_count)
          begin
            next_ld = 1'b0;
            next_state = `CRL_ST_IDLE;
          end
          else
            next_page = page + 4'h1;
        end
        else if (loc == `CRL_LAST_CTRL)
          next_loc = `CRL_COEF_BASE;
        else
          next_loc = loc + 7'h01;
      end
    end
    default:
    begin
      next_state = `CRL_ST_IDLE;
      next_ld = 1'b0;
      next_stb = 1'b0;
    end
  endcase
end

always @(posedge CORE_CLK)
begin
  if (SYS_RST)
  begin
    state <= `CRL_ST_IDLE;
    loc <= 7'h00;
    page <= 4'h0;
    acc_cnt <= 8'h00;
    ld <= 1'b0;
    stb <= 1'b0;
    boot_pend <= 1'b1;
    // Matches an idle select, so reset makes no restart edge
    cs_d <= 1'b0;
  end
  else
  begin
    state <= next_state;
    loc <= next_loc;
    page <= next_page;
    acc_cnt <= next_acc_cnt;
    ld <= next_ld;
    stb <= next_stb;
    cs_d <= cs_act;
    // Held until a head strap settles into EPROM mode
    if (state == `CRL_ST_IDLE && eprom_mode)
      boot_pend <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////
// Host path timing
reg tim_d;
reg rd_own;
wire tim_src = eprom_mode ? stb : (head ? stb_act : chain_act);
wire tim_rise = tim_src & ~tim_d;
wire sel = cs_act & config_load_active_act;
wire hwr = tim_rise & sel & ~rnw & ~eprom_mode;
wire hrd = tim_rise & sel & rnw & ~eprom_mode;
wire [7:0] hidx = idx_of(s_addr);
wire [7:0] eidx = idx_of(loc);
wire [7:0] rd_byte = (hidx == 8'hff) ? 8'h00 : regs[hidx[6:0]];

always @(posedge CORE_CLK)
begin
  if (SYS_RST)
  begin
    for (i = 0; i < `CRL_REG_COUNT; i = i + 1)
      regs[i] <= `CRL_REG_RST;
    regs[`CRL_MODE_B_ADDR] <= `CRL_MODE_B_RST;
  end
  else if (ep_wr && eidx != 8'hff)
    regs[eidx[6:0]] <= s_data;
  else if (hwr && hidx != 8'hff)
    regs[hidx[6:0]] <= s_data;
end

always @(posedge CORE_CLK)
begin
  if (SYS_RST)
  begin
    tim_d <= 1'b0;
    rd_own <= 1'b0;
    CHAIN_TIMING_OUT_N <= 1'b1;
    EXP_FWD_ADDR <= 7'h00;
    EXP_FWD_DATA <= 8'h00;
    READ_FWD_OUT <= 1'b0;
    FINAL_RESULT_OUT <= 8'h00;
    EXPANSION_DATA_LOW_OUT <= 8'h00;
    EXPANSION_DATA_LOW_OE <= 1'b0;
  end
  else
  begin
    tim_d <= tim_src;
    // Acknowledge trails capture by one cycle so data is already in
    CHAIN_TIMING_OUT_N <= ~tim_d;
    if (hrd)
      rd_own <= 1'b1;
    else if (~tim_src)
      rd_own <= 1'b0;
    EXP_FWD_ADDR <= eprom_mode ? loc : s_addr;
    if (hrd)
    begin
      EXP_FWD_DATA <= rd_byte;
      READ_FWD_OUT <= 1'b1;
      FINAL_RESULT_OUT <= rd_byte;
    end
    else if (~rd_own)
    begin
      EXP_FWD_DATA <= s_data;
      READ_FWD_OUT <= rd_fwd_in;
      if (rd_fwd_in)
        FINAL_RESULT_OUT <= s_data;
    end
    EXPANSION_DATA_LOW_OUT <= hrd ? rd_byte : EXPANSION_DATA_LOW_OUT;
    // Only a lone device may turn the data pins round
    EXPANSION_DATA_LOW_OE <= single & ~eprom_mode
      & (hrd | (rd_own & tim_src));
  end
end

////////////////////////////////////////////////////////////////////////
// EPROM-mode pin drivers
always @(posedge CORE_CLK)
begin
  if (SYS_RST)
  begin
    HOST_STROBE_N_OUT <= 1'b1;
    HOST_STROBE_OE <= 1'b0;
    CONFIG_LOAD_ACTIVE_N_OUT <= 1'b1;
    CONFIG_LOAD_ACTIVE_OE <= 1'b0;
    EXPANSION_ADDR_HIGH_OUT <= 7'h00;
    EXPANSION_ADDR_HIGH_OE <= 1'b0;
    PAGE_ADDR_OUT <= 4'h0;
  end
  else
  begin
    HOST_STROBE_N_OUT <= ~stb;
    HOST_STROBE_OE <= eprom_mode;
    CONFIG_LOAD_ACTIVE_N_OUT <= ~ld;
    CONFIG_LOAD_ACTIVE_OE <= eprom_mode;
    EXPANSION_ADDR_HIGH_OUT <= loc;
    EXPANSION_ADDR_HIGH_OE <= eprom_mode & ld;
    PAGE_ADDR_OUT <= page;
  end
end

endmodule

/* design/crl_map.vh */
// Constants for the cascaded register loader
`ifndef CRL_MAP_VH
`define CRL_MAP_VH
`define CRL_ADDR_W 7
`define CRL_DATA_W 8
`define CRL_PAGE_W 4
`define CRL_REG_COUNT 73
`define CRL_CTRL_COUNT 9
`define CRL_LAST_CTRL 7'h08
`define CRL_COEF_BASE 7'h40
`define CRL_LAST_LOC 7'h7f
`define CRL_MODE_A_ADDR 7'h00
`define CRL_MODE_B_ADDR 7'h01
`define CRL_COUNT_MSB 3
`define CRL_COUNT_LSB 0
`define CRL_REG_RST 8'h00
`define CRL_MODE_B_RST 8'h01
`define CRL_CLK_PERIOD_NS 50
`define CRL_EPROM_ACC_NS 250
`define CRL_SYNC_CYC 2
`define CRL_SYNC_W 24
`define CRL_SYNC_RST 24'hff0000
`define CRL_ST_IDLE 4'h1
`define CRL_ST_SETUP 4'h2
`define CRL_ST_STROBE 4'h4
`define CRL_ST_RELEASE 4'h8
`endif

/* tb/crl_eprom.sv */
// EPROM and downstream chain model
`timescale 1ns/10ps
module crl_eprom (
  input wire clk,
  input wire slow,
  input wire [3:0] page,
  input wire [6:0] loc,
  input wire strobe_n,
  output wire [7:0] data,
  output wire chain_n
);
  reg [3:0] dly = 4'hf;
  always @(posedge clk)
    dly <= {dly[2:0], strobe_n};
  // Slow chain widens the strobe
  assign chain_n = slow ? dly[3] : dly[0];
  // Byte 0 of page 0 sets a count of 2
  assign data = {page, 4'h2} ^ {1'b0, loc};
endmodule

/* tb/crl_loader_sva.sv */
// Port checker for the register loader
`timescale 1ns/10ps
module crl_chk (
  input wire CORE_CLK,
  input wire SYS_RST,
  input wire ROLE_SINGLE,
  input wire BOOT_SOURCE_SEL,
  input wire HOST_STROBE_N_IN,
  input wire HOST_STROBE_N_OUT,
  input wire HOST_STROBE_OE,
  input wire CONFIG_LOAD_ACTIVE_OE,
  input wire EXPANSION_ADDR_HIGH_OE,
  input wire EXPANSION_DATA_LOW_OE,
  input wire CONFIG_LOAD_ACTIVE_N_OUT,
  input wire [6:0] EXPANSION_ADDR_HIGH_OUT,
  input wire CHAIN_TIMING_IN_N,
  input wire CHAIN_TIMING_OUT_N,
  input wire [3:0] PAGE_ADDR_OUT
);
  wire hm = BOOT_SOURCE_SEL;
  wire so = HOST_STROBE_OE;
  wire sl = !HOST_STROBE_N_OUT;
  wire ld = CONFIG_LOAD_ACTIVE_N_OUT;
  wire ak = CHAIN_TIMING_OUT_N;
  wire [6:0] ea = EXPANSION_ADDR_HIGH_OUT;
  wire [3:0] pg = PAGE_ADDR_OUT;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  a_strobe_drv: assert property (so |-> !hm) else $error("strobe out in host mode");
  a_ack_cause: assert property (hm && $fell(ak) |-> !$past(HOST_STROBE_N_IN, 2)) else $error("early ack");
  a_ack_drop: assert property ((hm && HOST_STROBE_N_IN) [*6] |-> ak) else $error("ack stuck");
  a_load_start: assert property ($fell(SYS_RST) && !hm |-> ##[1:12] !ld) else $error("no load");
  a_load_end: assert property (!hm && $rose(ld) |-> $past(ea) == 7'h7f) else $error("early end");
  a_skip_mid: assert property (so && sl |-> ea <= 7'h08 || ea >= 7'h40) else $error("mid location");
  a_strobe_hold: assert property (so && sl && CHAIN_TIMING_IN_N |=> sl) else $error("short strobe");
  a_page_step: assert property (so && !ld && !$past(ld) && $changed(pg) |-> pg == $past(pg) + 4'h1)
    else $error("page skip");
  a_addr_drive: assert property (EXPANSION_ADDR_HIGH_OE == (CONFIG_LOAD_ACTIVE_OE && !ld))
    else $error("address drive");
  a_load_drive: assert property (CONFIG_LOAD_ACTIVE_OE == so) else $error("load drive");
  a_data_dir: assert property (EXPANSION_DATA_LOW_OE |-> ROLE_SINGLE && hm) else $error("data driven");
  c_load: cover property ($fell(ld));
  c_ack: cover property (hm && $fell(ak));
  c_page: cover property (!ld && $changed(pg));
endmodule
////////////////////////////////////////
bind crl_loader crl_chk chk_u (.CORE_CLK, .SYS_RST, .ROLE_SINGLE, .BOOT_SOURCE_SEL, .HOST_STROBE_N_IN,
  .HOST_STROBE_N_OUT, .HOST_STROBE_OE, .CONFIG_LOAD_ACTIVE_OE, .EXPANSION_ADDR_HIGH_OE,
  .EXPANSION_DATA_LOW_OE, .CONFIG_LOAD_ACTIVE_N_OUT, .EXPANSION_ADDR_HIGH_OUT, .CHAIN_TIMING_IN_N,
  .CHAIN_TIMING_OUT_N, .PAGE_ADDR_OUT);

/* tb/test_crl_loader.sv */
// Self-checking bench for the register loader
`timescale 1ns/10ps
`include "crl_map.vh"
module test_crl_loader;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg sgl = 1'b1;
  reg boot = 1'b1;
  reg slow = 1'b0;
  reg cs_n = 1'b1;
  reg rnw = 1'b0;
  reg st_n = 1'b1;
  reg [6:0] ha = 7'h00;
  reg [7:0] hd = 8'h00;
  reg [31:0] lf = 32'h49d9;
  reg [6:0] at [0:5] = '{7'h7f, 7'h40, 7'h08, 7'h00, 7'h09, 7'h3f};
  reg [7:0] dv [0:5];
  integer bad_count = 0;
  integer cmp_count = 0;
  integer i, j, k;
  logic [7:0] dq [$];
  logic [10:0] aq [$];
  logic [15:0] fq [$];
  logic [15:0] fx;
  wire so_n, so_oe, lo_n, lo_oe, ao_oe, do_oe, ct_i, ct_o, rf;
  wire [6:0] ao, fa;
  wire [7:0] dout, fr, rd, fd;
  wire [3:0] pg;
  // Released lines fall back to the bench level, as a pull-up would
  wire st_w = so_oe ? so_n : st_n;
  wire ld_w = lo_oe ? lo_n : cs_n;
  wire [6:0] a_w = ao_oe ? ao : ha;
  wire [7:0] d_w = do_oe ? dout : (boot ? hd : rd);
  crl_loader dut_u (.CORE_CLK(clk), .SYS_RST(rst), .ROLE_SINGLE(sgl), .ROLE_MASTER_N(1'b0),
    .BOOT_SOURCE_SEL(boot), .CHIP_SEL_N(cs_n), .READ_NOT_WRITE(rnw), .HOST_STROBE_N_IN(st_w),
    .HOST_STROBE_N_OUT(so_n), .HOST_STROBE_OE(so_oe), .CONFIG_LOAD_ACTIVE_N_IN(ld_w),
    .CONFIG_LOAD_ACTIVE_N_OUT(lo_n), .CONFIG_LOAD_ACTIVE_OE(lo_oe), .EXPANSION_ADDR_HIGH_IN(a_w),
    .EXPANSION_ADDR_HIGH_OUT(ao), .EXPANSION_ADDR_HIGH_OE(ao_oe), .EXPANSION_DATA_LOW_IN(d_w),
    .EXPANSION_DATA_LOW_OUT(dout), .EXPANSION_DATA_LOW_OE(do_oe), .READ_FWD_IN(1'b0), .READ_FWD_OUT(rf),
    .EXP_FWD_ADDR(fa), .EXP_FWD_DATA(fd), .CHAIN_TIMING_IN_N(ct_i), .CHAIN_TIMING_OUT_N(ct_o),
    .FINAL_RESULT_OUT(fr), .PAGE_ADDR_OUT(pg));
  // EPROM and chain see the pins, strobe pull-up included
  crl_eprom rom_u (.clk(clk), .slow(slow), .page(pg), .loc(a_w), .strobe_n(st_w), .data(rd), .chain_n(ct_i));
  always #25 clk = ~clk;
  ////////////////////////////////////////
  function [31:0] nx(input [31:0] v);
    nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task end_sim;
  begin
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  task ck(input logic [10:0] g, input logic [10:0] x);
  begin
    cmp_count++;
    if (g !== x)
    begin
      $display("mismatch at %0t: got %h want %h", $time, g, x);
      bad_count++;
    end
  end
  endtask
  // Bounded wait on load signal or acknowledge
  task w(input bit s, input logic v);
  begin
    for (k = 0; k < 20000 && (s ? lo_n : ct_o) !== v; k++)
      @(negedge clk);
    if (k == 20000)
    begin
      $display("mismatch at %0t: timeout", $time);
      bad_count++;
      end_sim;
    end
  end
  endtask
  task hx(input logic r, input logic [6:0] a, input logic [7:0] d);
  begin
    @(negedge clk);
    fq.push_back({r, a, d});
    cs_n = 1'b0;
    rnw = r;
    ha = a;
    hd = d;
    st_n = 1'b0;
    w(0, 1'b0);
    st_n = 1'b1;
    w(0, 1'b1);
    cs_n = 1'b1;
  end
  endtask
  ////////////////////////////////////////
  always @(negedge ct_o)
    if (boot)
    begin
      #1;
      fx = fq.pop_front();
      ck({rf, fa}, fx[15:8]);
      if (rnw)
      begin
        ck(fd, dq[0]);
        ck(fr, dq[0]);
        ck(do_oe ? dout : 8'hxx, dq.pop_front());
      end
      else
        ck(fd, fx[7:0]);
    end
  always @(negedge so_n)
    if (so_oe)
    begin
      #1;
      ck({pg, ao}, aq.pop_front());
    end
  initial
  begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    dq.push_back(`CRL_REG_RST);
    hx(1'b1, `CRL_MODE_A_ADDR, 8'h00);
    dq.push_back(`CRL_MODE_B_RST);
    hx(1'b1, `CRL_MODE_B_ADDR, 8'h00);
    for (i = 0; i < 12; i++)
    begin
      lf = nx(lf);
      if (i < 6)
        dv[i] = lf[7:0];
      else
        dq.push_back(at[i-6] <= `CRL_LAST_CTRL || at[i-6] >= `CRL_COEF_BASE ? dv[i-6] : 8'h00);
      hx(i >= 6, at[i % 6], dv[i % 6]);
    end
    $display("host test done");
    rst = 1'b1;
    boot = 1'b0;
    rnw = 1'b0;
    sgl = 1'b0;
    repeat (4) @(negedge clk);
    for (j = 0; j < 2; j++)
    begin
      for (k = 0; k < 384; k++)
        if (k % 128 <= 8 || k % 128 >= 64)
          aq.push_back(k[10:0]);
      rst = 1'b0;
      cs_n = ~j[0];
      w(1, 1'b0);
      cs_n = 1'b1;
      w(1, 1'b1);
      ck(aq.size(), 11'h0);
      slow = 1'b1;
    end
    $display("eprom test done");
    end_sim;
  end
endmodule
